// ### verilog/cmp_defines.svh
// Register offsets, field positions and reset values of the comparator block
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

`define CH1_CTRL_ADDR     12'h000
`define CH2_CTRL_ADDR     12'h004
`define CH3_CTRL_ADDR     12'h008
`define STATUS_ADDR       12'h00c
`define REF_CTRL_ADDR     12'h010

`define CTRL_ON_BIT       15
`define CTRL_PIN_BIT      14
`define CTRL_INV_BIT      13
`define CTRL_EVT_BIT      9
`define CTRL_RES_BIT      8
`define CTRL_EDGE_HI      7
`define CTRL_EDGE_LO      6
`define CTRL_NONINV_BIT   4
`define CTRL_INVSEL_HI    1
`define CTRL_INVSEL_LO    0
`define CTRL_WMASK        16'he0d3

`define STAT_IDLE_BIT     15
`define STAT_EVT_LO       8
`define STAT_RES_LO       0

`define REF_WMASK         16'h07ff
`define REF_PICK_BIT      10
`define REF_SRC_HI        9
`define REF_SRC_LO        8
`define REF_POWER_BIT     7
`define REF_PINOUT_BIT    6
`define REF_SUPPLY_BIT    5
`define REF_LEVEL_HI      4
`define REF_LEVEL_LO      0

`define REG_RESET         16'h0000

`endif

// ### verilog/cmp_pkg.sv
// Types shared by the comparator control block
package cmp_pkg;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY  = 2'h3
    } edge_sel_e;

    typedef enum logic [1:0] {
        INV_PIN_B = 2'h0,
        INV_PIN_C = 2'h1,
        INV_PIN_D = 2'h2,
        INV_REF   = 2'h3
    } inv_sel_e;

    typedef enum logic [1:0] {
        SRC_BAND_GAP = 2'h0,
        SRC_RSVD_1   = 2'h1,
        SRC_RSVD_2   = 2'h2,
        SRC_PIN_POS  = 2'h3
    } ref_src_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_e;

    typedef logic [15:0] reg16_t;
endpackage : cmp_pkg

// ### verilog/triple_comparator_control.sv
// Control, status and event logic for three comparators and their reference
`include "cmp_defines.svh"

module triple_comparator_control (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    // AHB-Lite slave
    input  wire logic             hsel_i,
    input  wire logic [11:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    // Device power state
    input  wire logic             device_idle_i,
    // Analog cores
    input  wire logic [2:0]       raw_result_i,
    output logic      [2:0]       channel_on_o,
    output logic      [2:0]       result_invert_o,
    output logic      [2:0]       noninv_input_select_o,
    output logic      [5:0]       inv_input_select_o,
    output logic      [2:0]       pin_drive_enable_o,
    output logic                  ladder_or_pin_pick_o,
    output logic      [1:0]       reference_source_field_o,
    output logic                  ladder_power_on_o,
    output logic                  ladder_pin_output_o,
    output logic                  ladder_supply_select_o,
    output logic      [4:0]       ladder_level_code_o,
    // Events toward interrupt controller and peripherals
    output logic      [2:0]       event_irq_o,
    output logic      [2:0]       event_trigger_o
);
    import cmp_pkg::*;

    // Registers
    reg16_t      ctrl_q [3];
    reg16_t      ref_q;
    logic        idle_stop_all_q;
    logic [2:0]  channel_event_flag_q;
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic [2:0]  res_prev_q;
    logic [2:0]  run_prev_q;
    bus_state_e  bus_q;
    logic        wr_pend_q;
    logic [11:0] addr_q;

    // Edge detection shared by the three channels
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev, input logic now);
        logic rise;
        logic fall;
        rise = ~prev & now;
        fall = prev & ~now;
        case (edge_sel_e'(sel))
            EDGE_ANY:  edge_hit = rise | fall;
            EDGE_FALL: edge_hit = fall;
            EDGE_RISE: edge_hit = rise;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Bus decode
    wire         addr_ok  = hsel_i & hready_i & htrans_i[1];
    wire         wr_req   = addr_ok & hwrite_i;
    wire         rd_req   = addr_ok & ~hwrite_i;
    wire         w_ch1    = wr_pend_q & (addr_q == `CH1_CTRL_ADDR);
    wire         w_ch2    = wr_pend_q & (addr_q == `CH2_CTRL_ADDR);
    wire         w_ch3    = wr_pend_q & (addr_q == `CH3_CTRL_ADDR);
    wire         w_stat   = wr_pend_q & (addr_q == `STATUS_ADDR);
    wire         w_ref    = wr_pend_q & (addr_q == `REF_CTRL_ADDR);
    wire [2:0]   w_ch     = {w_ch3, w_ch2, w_ch1};
    wire [15:0]  wdata    = hwdata_i[15:0];

    // Comparator stop in idle
    wire         idle_stop = idle_stop_all_q & device_idle_i;
    logic [2:0]  run;
    logic [2:0]  result;
    logic [2:0]  hit;
    logic [2:0]  set_evt;
    logic [2:0]  clr_evt;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            run[i] = ctrl_q[i][`CTRL_ON_BIT] & ~idle_stop;
            // Result reads zero while stopped; synced copy only
            result[i] = run[i] &
                (sync2_q[i] ^ ctrl_q[i][`CTRL_INV_BIT]);
            // Edges across a run start are not real transitions
            // Judged on the core's own sense: polarity only renames them
            hit[i] = run[i] & run_prev_q[i] & edge_hit(
                ctrl_q[i][`CTRL_EDGE_HI:`CTRL_EDGE_LO],
                res_prev_q[i], run[i] & sync2_q[i]);
            set_evt[i] = hit[i] & ~channel_event_flag_q[i];
            clr_evt[i] = w_ch[i] & ~wdata[`CTRL_EVT_BIT];
        end
    end

    // Read mux
    wire [15:0] status_rd = {idle_stop_all_q, 4'h0,
                             channel_event_flag_q, 5'h00,
                             result};
    function automatic reg16_t ctrl_rd(input reg16_t c, input logic evt,
                                       input logic res);
        reg16_t v;
        v = c & `CTRL_WMASK;
        v[`CTRL_EVT_BIT] = evt;
        v[`CTRL_RES_BIT] = res;
        ctrl_rd = v;
    endfunction : ctrl_rd

    wire [15:0] rd_mux =
        (haddr_i == `CH1_CTRL_ADDR) ? ctrl_rd(ctrl_q[0],
            channel_event_flag_q[0], result[0]) :
        (haddr_i == `CH2_CTRL_ADDR) ? ctrl_rd(ctrl_q[1],
            channel_event_flag_q[1], result[1]) :
        (haddr_i == `CH3_CTRL_ADDR) ? ctrl_rd(ctrl_q[2],
            channel_event_flag_q[2], result[2]) :
        (haddr_i == `STATUS_ADDR)   ? status_rd :
        (haddr_i == `REF_CTRL_ADDR) ? (ref_q & `REF_WMASK) :
        16'h0000;

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_q     <= BUS_IDLE;
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
            hrdata_o  <= 32'h0000_0000;
        end else begin
            case (bus_q)
                BUS_IDLE: bus_q <= addr_ok ? BUS_DATA : BUS_IDLE;
                BUS_DATA: bus_q <= addr_ok ? BUS_DATA : BUS_IDLE;
                default:  bus_q <= BUS_IDLE;
            endcase
            wr_pend_q <= wr_req;
            addr_q    <= haddr_i;
            if (rd_req) begin
                hrdata_o <= {16'h0000, rd_mux};
            end
        end
    end

    // Control registers and event flags
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_q[i] <= `REG_RESET;
            end
            ref_q                <= `REG_RESET;
            idle_stop_all_q      <= 1'b0;
            channel_event_flag_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (w_ch[i]) begin
                    ctrl_q[i] <= wdata & `CTRL_WMASK;
                end
                // Set only fires on a clear flag, so a same-cycle software clear of a set flag wins
                if (set_evt[i]) begin
                    channel_event_flag_q[i] <= 1'b1;
                end else if (clr_evt[i]) begin
                    channel_event_flag_q[i] <= 1'b0;
                end
            end
            if (w_stat) begin
                idle_stop_all_q <= wdata[`STAT_IDLE_BIT];
            end
            if (w_ref) begin
                ref_q <= wdata & `REF_WMASK;
            end
        end
    end

    // Synchroniser and edge history
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q    <= 3'h0;
            sync2_q    <= 3'h0;
            res_prev_q <= 3'h0;
            run_prev_q <= 3'h0;
        end else begin
            sync1_q    <= raw_result_i;
            sync2_q    <= sync1_q;
            res_prev_q <= run & sync2_q;
            run_prev_q <= run;
        end
    end

    // Registered outputs to analog and event consumers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            channel_on_o             <= 3'h0;
            result_invert_o          <= 3'h0;
            noninv_input_select_o    <= 3'h0;
            inv_input_select_o       <= 6'h00;
            pin_drive_enable_o       <= 3'h0;
            ladder_or_pin_pick_o     <= 1'b0;
            reference_source_field_o <= 2'h0;
            ladder_power_on_o        <= 1'b0;
            ladder_pin_output_o      <= 1'b0;
            ladder_supply_select_o   <= 1'b0;
            ladder_level_code_o      <= 5'h00;
            event_irq_o              <= 3'h0;
            event_trigger_o          <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                channel_on_o[i] <= run[i];
                result_invert_o[i] <= ctrl_q[i][`CTRL_INV_BIT];
                noninv_input_select_o[i] <=
                    ctrl_q[i][`CTRL_NONINV_BIT];
                inv_input_select_o[2*i +: 2] <=
                    ctrl_q[i][`CTRL_INVSEL_HI:`CTRL_INVSEL_LO];
                // Pad drives the unsynchronised core output
                pin_drive_enable_o[i] <=
                    run[i] & ctrl_q[i][`CTRL_PIN_BIT];
            end
            ladder_or_pin_pick_o     <= ref_q[`REF_PICK_BIT];
            reference_source_field_o <=
                ref_q[`REF_SRC_HI:`REF_SRC_LO];
            ladder_power_on_o        <= ref_q[`REF_POWER_BIT];
            ladder_pin_output_o      <= ref_q[`REF_PINOUT_BIT];
            ladder_supply_select_o   <= ref_q[`REF_SUPPLY_BIT];
            ladder_level_code_o      <=
                ref_q[`REF_LEVEL_HI:`REF_LEVEL_LO];
            event_irq_o              <= set_evt;
            event_trigger_o          <= set_evt;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
endmodule : triple_comparator_control

// ### dv/cmp_analog_model.sv
// Behavioural comparator cores fed from four shared pin levels
module cmp_analog_model (
    // Control from the block
    input  logic [2:0] on_i,
    input  logic [2:0] noninv_i,
    input  logic [5:0] inv_i,
    input  logic [4:0] level_i,
    // Pins A to D, then results
    input  logic [7:0] pin_i [4],
    output logic [2:0] raw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lvl, pl, mi;
    // Tap in pin units: code 20 sits at 160
    assign lvl = {level_i, 3'h0};
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            pl = noninv_i[c] ? lvl : pin_i[0];
            mi = &inv_i[2*c+:2] ? lvl : pin_i[inv_i[2*c+:2]+1];
            raw_o[c] = on_i[c] && pl > mi; // Stopped core low
        end
    end
endmodule : cmp_analog_model

// ### dv/triple_comparator_control_asserts.sv
// Port-level checks of the comparator control block
module triple_comparator_control_asserts (
    // Clock and reset
    input logic        clk_sys_i,
    input logic        rst_i,
    // Bus
    input logic        hsel_i,
    input logic [11:0] haddr_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic [31:0] hwdata_i,
    input logic [31:0] hrdata_o,
    input logic        hreadyout_o,
    // Analog side and events
    input logic [2:0]  raw_result_i,
    input logic [2:0]  channel_on_o,
    input logic [2:0]  pin_drive_enable_o,
    input logic [4:0]  ladder_level_code_o,
    input logic [2:0]  event_irq_o,
    input logic [2:0]  event_trigger_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       req;
    logic [3:0] quiet_q;
    assign req = hsel_i && hreadyout_o && htrans_i[1];
    // Writes restart the count too, though a polarity flip is no result edge: edges are judged on the core's own sense
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) quiet_q <= 4'hf;
        else if ($changed(raw_result_i) || (req && hwrite_i)) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence ref_wr_s;
        req && hwrite_i && haddr_i == 12'h010 ##1 1'b1;
    endsequence
    status_fmt_a: assert property (req && !hwrite_i && haddr_i == 12'h00c
        |=> (hrdata_o & 32'hffff_78f8) == 32'h0) else $error("status spare bits");
    unmapped_zero_a: assert property (req && !hwrite_i && haddr_i > 12'h010
        |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
    irq_trig_a: assert property (event_irq_o == event_trigger_o)
        else $error("irq and trigger differ");
    irq_pulse_a: assert property (|event_irq_o
        |=> (event_irq_o & $past(event_irq_o)) == 3'h0) else $error("long irq");
    irq_cause_a: assert property (|event_irq_o |-> quiet_q < 4'd12)
        else $error("event without a cause");
    pin_gate_a: assert property ((pin_drive_enable_o & ~channel_on_o) == 3'h0)
        else $error("pin driven by stopped channel");
    ref_follow_a: assert property (ref_wr_s
        |-> ##2 ladder_level_code_o == $past(hwdata_i[4:0], 2)) else $error("level");
    reset_zero_a: assert property ($fell(rst_i)
        |-> channel_on_o == 3'h0 && ladder_level_code_o == 5'h0) else $error("reset");
endmodule : triple_comparator_control_asserts

bind triple_comparator_control triple_comparator_control_asserts u_chk (
    .clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
    .hrdata_o, .hreadyout_o, .raw_result_i, .channel_on_o, .pin_drive_enable_o,
    .ladder_level_code_o, .event_irq_o, .event_trigger_o);

// ### dv/tb.sv
// Register-level bench for the comparator control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i, rst_i, hwrite, idle, bad;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, rd_v;
    logic [15:0] cfg;
    logic [7:0]  pin [4];
    wire  [31:0] hrdata;
    wire         hready;
    wire  [2:0]  raw, on, noninv, pin_en, irq, pol, trig;
    wire         resp;
    wire  [5:0]  inv_sel;
    wire  [10:0] refo;
    int          n_fail, checks_done, nirq, base;

    triple_comparator_control dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(resp), .device_idle_i(idle),
        .raw_result_i(raw), .channel_on_o(on), .result_invert_o(pol),
        .noninv_input_select_o(noninv), .inv_input_select_o(inv_sel),
        .pin_drive_enable_o(pin_en), .ladder_or_pin_pick_o(refo[10]),
        .reference_source_field_o(refo[9:8]), .ladder_power_on_o(refo[7]),
        .ladder_pin_output_o(refo[6]), .ladder_supply_select_o(refo[5]),
        .ladder_level_code_o(refo[4:0]), .event_irq_o(irq),
        .event_trigger_o(trig));
    cmp_analog_model partner (.on_i(on), .noninv_i(noninv), .inv_i(inv_sel),
        .level_i(refo[4:0]), .pin_i(pin), .raw_o(raw));

    task automatic tally_and_finish;
        n_fail += int'(bad);
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        {haddr, htrans, hwrite} <= {a, 2'h2, w};
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do @(posedge clk_sys_i); while (hready !== 1'b1 && ++n < 20);
            bad |= n == 20;
            {htrans, hwdata} <= {2'h0, d};
        end
        rd_v = hrdata;
    endtask : bus

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask : rdc

    // Pin moves on an edge, then the synchroniser gets time to settle
    task automatic step(input logic [7:0] v);
        @(posedge clk_sys_i);
        pin[0] <= v;
        repeat (8) @(posedge clk_sys_i);
    endtask : step

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Counts only channel 0 pulses seen on both event outputs together
    always @(posedge clk_sys_i)
        nirq <= nirq + int'(irq[0] === 1'b1 && trig[0] === 1'b1);
    always @(posedge clk_sys_i) if (bad) tally_and_finish();

    initial begin
        {rst_i, hwrite, idle, bad} = 4'h8;
        {haddr, htrans, hwdata} = '0;
        pin = '{8'd100, 8'd50, 8'd150, 8'd50};
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 24; a += 4) rdc(12'(a), 32'h0);
        chk(32'(resp), 32'h0);
        bus(1'b1, 12'h010, 32'hffff_ffff);
        rdc(12'h010, 32'h07ff);
        chk(32'(refo), 32'h07ff);
        bus(1'b1, 12'h010, 32'h0094);
        rdc(12'h010, 32'h0094);
        for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 5; s++) begin
                bus(1'b1, 12'(4 * c), s < 4 ? 32'hc000 | s : 32'hc010);
                step(8'd100);
                rdc(12'h00c, (32'h15 >> s & 1) << c);
                chk(32'(pin_en), 32'h1 << c);
            end
            bus(1'b1, 12'(4 * c), 32'h0);
        end
        for (int e = 0; e < 4; e++) begin
            for (int p = 0; p < 2; p++) begin
                cfg = 16'h8000 | 16'(p << 13) | 16'(e << 6);
                bus(1'b1, 12'h000, 32'(cfg));
                step(8'd40);
                bus(1'b1, 12'h000, 32'(cfg));
                step(8'd40);
                base = nirq;
                step(8'd60);
                chk(nirq - base, e % 2);
                rdc(12'h00c, 32'(e % 2) << 8 | 32'(p ^ 1));
                chk(32'(pol), 32'(p));
                step(8'd40);
                chk(nirq - base, e != 0);
                bus(1'b1, 12'h000, 32'(cfg));
                rdc(12'h000, 32'(cfg) | 32'(p << 8));
            end
        end
        bus(1'b1, 12'h000, 32'h8000);
        bus(1'b1, 12'h00c, 32'hffff);
        rdc(12'h00c, 32'h8000);
        idle <= 1'b1;
        step(8'd40);
        chk(32'(on), 32'h0);
        bus(1'b1, 12'h00c, 32'h0);
        step(8'd40);
        chk(32'(on), 32'h1);
        tally_and_finish();
    end
endmodule : tb
